// >>> logic/drive_cmd_pkg.sv
// Package for the drive run-command block: register map, source codes,
// latch states and the command carrier.
// Assumes a 32-bit Avalon-MM slave with byte addresses, word aligned.
package drive_cmd_pkg;

    // Sizes
    localparam int N_PIN  = 8;
    localparam int N_FN   = 12;
    localparam int N_LB   = 4;
    localparam int N_SEL  = N_FN + 3 * N_LB;
    localparam int SEL_W  = 6;

    // Function slots within the select array
    localparam int FN_LFWD   = 0;
    localparam int FN_LREV   = 1;
    localparam int FN_PERMIT = 2;
    localparam int FN_HFWD   = 3;
    localparam int FN_HREV   = 4;
    localparam int FN_UP     = 5;
    localparam int FN_DOWN   = 6;
    localparam int FN_TRIP   = 7;
    localparam int FN_OVR    = 8;
    localparam int FN_JOGF   = 9;
    localparam int FN_JOGR   = 10;
    localparam int FN_REMOTE = 11;
    localparam int FN_LB_IN0 = 12;

    // Source codes: pins 0..7, logic blocks 8..11, constants
    localparam logic [3:0] SRC_LB0 = 4'h8;
    localparam logic [3:0] SRC_OFF = 4'hC;
    localparam logic [3:0] SRC_ON  = 4'hD;

    // Qualifier codes in select bits 5:4
    typedef enum logic [1:0] {
        Q_HIGH = 2'h0,
        Q_LOW  = 2'h1,
        Q_RISE = 2'h2,
        Q_FALL = 2'h3
    } qual_t;

    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_SEL_BASE = 8'h00;
    localparam logic [7:0] OFS_TT_BASE  = 8'h60;
    localparam logic [7:0] OFS_CTRL     = 8'h70;
    localparam logic [7:0] OFS_STAT     = 8'h74;
    localparam logic [7:0] OFS_ASSIGN   = 8'h78;

    // Field positions
    localparam int CTRL_REV_PERMIT = 0;
    localparam int ASSIGN_IDX_LSB  = 8;
    localparam int ASSIGN_REMOVE   = 16;

    // Reset values
    localparam logic [5:0] SEL_RST  = 6'h0C;
    localparam logic [7:0] TT_RST   = 8'h00;
    localparam logic [0:0] CTRL_RST = 1'h0;

    // Latch state, one-hot
    typedef enum logic [2:0] {
        LS_IDLE = 3'h1,
        LS_FWD  = 3'h2,
        LS_REV  = 3'h4
    } latch_t;

    // Command bundle toward the motor controller
    typedef struct packed {
        logic run;
        logic reverse;
        logic jog;
        logic ref_up;
        logic ref_down;
        logic trip_reset;
        logic override;
        logic remote;
        logic bipolar;
    } drive_cmd_t;

endpackage : drive_cmd_pkg

// >>> logic/drive_run_command_logic.sv
// Run-command logic: maps terminal inputs to run, direction, jog, trip
// reset, override and reference requests, plus four truth-table blocks.
// Assumes terminal inputs synchronous to mclk and an Avalon-MM master.
//
// Contract
// - Latched forward pulse keeps motor running forward
// - Latched reverse pulse keeps motor running reverse
// - Reverse motion only with reverse permission set
// - Run permit low clears latches, stops motor (here hold and jog functions still run with permit low)
// - Local mode ignores run permit entirely
// - Hold forward runs only while held
// - Hold reverse runs only while held
// - Bipolar needs both hold functions assigned
// - Reference up only when console reference active
// - Reference down only when console reference active
// - Trip reset function requests trip reset
// - Override function held means override mode
// - Forward jog runs forward, clears latches
// - Reverse jog runs reverse, clears latches
// - Remote select obeys terminal functions
// - Remote inactive obeys console commands
// - Four three-input truth-table blocks
// - Input levels pick term, output is term
// - Block inputs selectable, outputs become sources
// - Assign with removal turns other users off (here only when the assigned source is a pin)
// - Select offers levels, edges, on, off
//
// The Avalon-MM slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps

module drive_run_command_logic (
    // Clock and reset
    input  wire logic                    mclk,
    input  wire logic                    rst,
    // Avalon-MM slave
    input  wire logic [7:0]              address,
    input  wire logic                    read,
    input  wire logic                    write,
    input  wire logic [31:0]             writedata,
    output logic      [31:0]             readdata,
    output logic                         waitrequest,
    // Terminal strip and console
    input  wire logic [7:0]              din,
    input  wire logic                    drive_enable,
    input  wire logic                    console_run,
    input  wire logic                    console_reverse,
    input  wire logic                    console_ref_active,
    // Commands to the motor controller
    output drive_cmd_pkg::drive_cmd_t    cmd
);

    localparam int NS = drive_cmd_pkg::N_SEL;

    logic                ack_q;
    logic [31:0]         rdata_q;
    logic [5:0]          sel_q [NS];
    logic [7:0]          tt_q [drive_cmd_pkg::N_LB];
    logic [0:0]          ctrl_q;
    logic [7:0]          din_q;
    logic [3:0]          lb_q;
    logic [3:0]          lb_d;
    logic [15:0]         src_lvl;
    logic [15:0]         src_prv_q;
    logic [NS-1:0]       fn_act;
    drive_cmd_pkg::latch_t     ls_q;
    drive_cmd_pkg::latch_t     ls_d;
    drive_cmd_pkg::drive_cmd_t cmd_q;
    drive_cmd_pkg::drive_cmd_t cmd_d;

    // Bus handshake: one wait cycle, then the access completes
    wire req     = read | write;
    wire aligned = (address[1:0] == 2'h0);
    wire wr_go   = write & ack_q & aligned;
    assign waitrequest = req & ~ack_q;
    assign readdata    = rdata_q;

    always_ff @(posedge mclk)
    begin
        if (rst)
            ack_q <= 1'b0;
        else
            ack_q <= req & ~ack_q;
    end

    // Assign register fields
    wire       asg_go  = wr_go & (address == drive_cmd_pkg::OFS_ASSIGN);
    wire [5:0] asg_sel = writedata[5:0];
    wire [4:0] asg_idx = writedata[drive_cmd_pkg::ASSIGN_IDX_LSB +: 5];
    wire       asg_rm  = writedata[drive_cmd_pkg::ASSIGN_REMOVE];
    wire       asg_pin = (asg_sel[3:0] < drive_cmd_pkg::SRC_LB0);
    wire       asg_ok  = (asg_idx < 5'(NS));

    // Source select registers; a plain write stores, the assign register
    // can also strip a pin from every other function in one access
    generate
        for (genvar i = 0; i < NS; i++)
        begin : g_sel
            wire hit   = wr_go & (address == drive_cmd_pkg::OFS_SEL_BASE + 8'(4 * i));
            wire mine  = asg_go & asg_ok & (asg_idx == 5'(i));
            wire strip = asg_go & asg_ok & asg_rm & asg_pin
                         & (sel_q[i][3:0] == asg_sel[3:0]);
            always_ff @(posedge mclk)
            begin
                if (rst)
                    sel_q[i] <= drive_cmd_pkg::SEL_RST;
                else if (hit)
                    sel_q[i] <= writedata[5:0];
                else if (mine)
                    sel_q[i] <= asg_sel;
                else if (strip)
                    sel_q[i] <= drive_cmd_pkg::SEL_RST;
            end
        end
    endgenerate

    // Truth tables, one per logic block
    generate
        for (genvar j = 0; j < drive_cmd_pkg::N_LB; j++)
        begin : g_tt
            wire hit = wr_go & (address == drive_cmd_pkg::OFS_TT_BASE + 8'(4 * j));
            always_ff @(posedge mclk)
            begin
                if (rst)
                    tt_q[j] <= drive_cmd_pkg::TT_RST;
                else if (hit)
                    tt_q[j] <= writedata[7:0];
            end
        end
    endgenerate

    // Control register: reverse permission
    always_ff @(posedge mclk)
    begin
        if (rst)
            ctrl_q <= drive_cmd_pkg::CTRL_RST;
        else if (wr_go & (address == drive_cmd_pkg::OFS_CTRL))
            ctrl_q <= writedata[drive_cmd_pkg::CTRL_REV_PERMIT +: 1];
    end

    wire rev_ok = ctrl_q[drive_cmd_pkg::CTRL_REV_PERMIT];

    // Status word shows commands, latch state and block outputs
    wire [31:0] stat_word = {16'h0, lb_q, 3'(ls_q), cmd_q};

    // Read selection; unmapped or unaligned addresses read zero
    wire in_sel = aligned & (address < drive_cmd_pkg::OFS_TT_BASE);
    wire in_tt  = aligned & (address >= drive_cmd_pkg::OFS_TT_BASE)
                  & (address < drive_cmd_pkg::OFS_CTRL);
    wire [31:0] rd_word =
        in_sel ? {26'h0, sel_q[address[6:2]]} :
        in_tt  ? {24'h0, tt_q[address[3:2]]} :
        (aligned & (address == drive_cmd_pkg::OFS_CTRL)) ? {31'h0, ctrl_q} :
        (aligned & (address == drive_cmd_pkg::OFS_STAT)) ? stat_word : 32'h0;

    // Read data captured in the wait cycle, held while ack is presented
    always_ff @(posedge mclk)
    begin
        if (rst)
            rdata_q <= 32'h0;
        else if (read & ~ack_q)
            rdata_q <= rd_word;
    end

    // Source levels: pins, registered block outputs, constants.
    // Block outputs are registered so that a block may feed another
    // block, or itself, without a combinational loop.
    assign src_lvl = {2'h0, 1'b1, 1'b0, lb_q, din_q};

    // Pin sample and previous levels for edge detection
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            din_q     <= 8'h00;
            src_prv_q <= 16'h0000;
        end
        else
        begin
            din_q     <= din;
            src_prv_q <= src_lvl;
        end
    end

    // Qualified function activity for every select slot
    generate
        for (genvar i = 0; i < NS; i++)
        begin : g_fn
            wire       lv = src_lvl[sel_q[i][3:0]];
            wire       pv = src_prv_q[sel_q[i][3:0]];
            wire [1:0] q  = sel_q[i][5:4];
            assign fn_act[i] =
                (q == drive_cmd_pkg::Q_HIGH) ? lv :
                (q == drive_cmd_pkg::Q_LOW)  ? ~lv :
                (q == drive_cmd_pkg::Q_RISE) ? (lv & ~pv) :
                                               (~lv & pv);
        end
    endgenerate

    // Logic blocks: input one is the index MSB
    generate
        for (genvar j = 0; j < drive_cmd_pkg::N_LB; j++)
        begin : g_lb
            localparam int B = drive_cmd_pkg::FN_LB_IN0 + 3 * j;
            wire [2:0] term = {fn_act[B], fn_act[B + 1], fn_act[B + 2]};
            assign lb_d[j] = tt_q[j][term];
        end
    endgenerate

    always_ff @(posedge mclk)
    begin
        if (rst)
            lb_q <= 4'h0;
        else
            lb_q <= lb_d;
    end

    // Permit, jog, hold and latch functions count only in remote mode
    wire remote  = fn_act[drive_cmd_pkg::FN_REMOTE];
    wire permit  = ~remote | fn_act[drive_cmd_pkg::FN_PERMIT];
    wire jog_f   = remote & fn_act[drive_cmd_pkg::FN_JOGF];
    wire jog_r   = remote & fn_act[drive_cmd_pkg::FN_JOGR];
    wire jog_any = jog_f | jog_r;
    wire hold_f  = remote & fn_act[drive_cmd_pkg::FN_HFWD] & drive_enable;
    wire hold_r  = remote & fn_act[drive_cmd_pkg::FN_HREV] & drive_enable;
    wire st_f    = remote & fn_act[drive_cmd_pkg::FN_LFWD];
    wire st_r    = remote & fn_act[drive_cmd_pkg::FN_LREV] & rev_ok;

    // Bipolar needs both hold functions tied to a real source
    wire bip = (sel_q[drive_cmd_pkg::FN_HFWD][3:0] != drive_cmd_pkg::SRC_OFF)
             & (sel_q[drive_cmd_pkg::FN_HREV][3:0] != drive_cmd_pkg::SRC_OFF);

    // Latch machine; jog or loss of permit breaks the latch
    always_comb
    begin
        ls_d = ls_q;
        case (ls_q)
            drive_cmd_pkg::LS_IDLE,
            drive_cmd_pkg::LS_FWD,
            drive_cmd_pkg::LS_REV:
            begin
                if (~permit | jog_any)
                    ls_d = drive_cmd_pkg::LS_IDLE;
                else if (st_f)
                    ls_d = drive_cmd_pkg::LS_FWD;
                else if (st_r)
                    ls_d = drive_cmd_pkg::LS_REV;
            end
            default:
                ls_d = drive_cmd_pkg::LS_IDLE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            ls_q <= drive_cmd_pkg::LS_IDLE;
        else
            ls_q <= ls_d;
    end

    // Command selection: jog over hold over latch; console in local
    always_comb
    begin
        cmd_d            = '0;
        cmd_d.remote     = remote;
        cmd_d.bipolar    = bip;
        cmd_d.trip_reset = fn_act[drive_cmd_pkg::FN_TRIP];
        cmd_d.override   = fn_act[drive_cmd_pkg::FN_OVR];
        cmd_d.ref_up     = fn_act[drive_cmd_pkg::FN_UP] & console_ref_active;
        cmd_d.ref_down   = fn_act[drive_cmd_pkg::FN_DOWN] & console_ref_active;
        if (~remote)
        begin
            cmd_d.run     = console_run;
            cmd_d.reverse = console_reverse & rev_ok;
        end
        else if (jog_f)
        begin
            cmd_d.run = 1'b1;
            cmd_d.jog = 1'b1;
        end
        else if (jog_r)
        begin
            cmd_d.run     = rev_ok;
            cmd_d.reverse = rev_ok;
            cmd_d.jog     = rev_ok;
        end
        else if (hold_f)
            cmd_d.run = 1'b1;
        else if (hold_r)
        begin
            cmd_d.run     = rev_ok;
            cmd_d.reverse = rev_ok;
        end
        else if (ls_q == drive_cmd_pkg::LS_FWD)
            cmd_d.run = permit;
        else if (ls_q == drive_cmd_pkg::LS_REV)
        begin
            cmd_d.run     = permit & rev_ok;
            cmd_d.reverse = permit & rev_ok;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            cmd_q <= '0;
        else
            cmd_q <= cmd_d;
    end

    assign cmd = cmd_q;

    // Checks on the behaviour above
    a_latched_forward_start_set: assert property (@(posedge mclk) disable iff (rst)
        (st_f & permit & ~jog_any) |=> (ls_q == drive_cmd_pkg::LS_FWD)
            ##1 (ls_q == drive_cmd_pkg::LS_FWD) or (~permit | jog_any | st_r))
        else $error("forward latch not held");

    a_latched_reverse_start_set: assert property (@(posedge mclk) disable iff (rst)
        (st_r & ~st_f & permit & ~jog_any) |=> (ls_q == drive_cmd_pkg::LS_REV))
        else $error("reverse latch not set");

    a_no_reverse_run: assert property (@(posedge mclk) disable iff (rst)
        ~rev_ok |=> ~cmd_q.reverse)
        else $error("reverse without permission");

    a_permit_clears: assert property (@(posedge mclk) disable iff (rst)
        (remote & ~fn_act[drive_cmd_pkg::FN_PERMIT]) |=>
            (ls_q == drive_cmd_pkg::LS_IDLE))
        else $error("permit loss did not clear latch");

    a_local_keeps: assert property (@(posedge mclk) disable iff (rst)
        (~remote & (ls_q != drive_cmd_pkg::LS_IDLE)) |=>
            (ls_q == $past(ls_q)))
        else $error("latch lost in local mode");

    a_hold_fwd_run: assert property (@(posedge mclk) disable iff (rst)
        (hold_f & ~jog_any) |=> (cmd_q.run & ~cmd_q.reverse))
        else $error("hold forward not running");

    a_hold_rev_run: assert property (@(posedge mclk) disable iff (rst)
        (hold_r & rev_ok & ~hold_f & ~jog_any) |=> (cmd_q.run & cmd_q.reverse))
        else $error("hold reverse not running");

    a_bipolar_flag: assert property (@(posedge mclk) disable iff (rst)
        cmd_q.bipolar |-> ($past(sel_q[drive_cmd_pkg::FN_HREV][3:0])
            != drive_cmd_pkg::SRC_OFF))
        else $error("bipolar without reverse source");

    a_ref_gated: assert property (@(posedge mclk) disable iff (rst)
        ~console_ref_active |=> (~cmd_q.ref_up & ~cmd_q.ref_down))
        else $error("reference moved while not active");

    a_jog_clears: assert property (@(posedge mclk) disable iff (rst)
        jog_f |=> (cmd_q.jog & cmd_q.run & (ls_q == drive_cmd_pkg::LS_IDLE)))
        else $error("forward jog wrong");

    a_block_term: assert property (@(posedge mclk) disable iff (rst)
        (fn_act[14:12] == 3'h0) |=> (lb_q[0] == $past(tt_q[0][0])))
        else $error("logic block term m0 wrong");

    a_bus_one_wait: assert property (@(posedge mclk) disable iff (rst)
        (req & waitrequest) |=> ~waitrequest)
        else $error("bus wait longer than one cycle");

    a_local_console: assert property (@(posedge mclk) disable iff (rst)
        ~remote |=> (cmd_q.run == $past(console_run)))
        else $error("local run not from console");

    a_override_follow: assert property (@(posedge mclk) disable iff (rst)
        fn_act[drive_cmd_pkg::FN_OVR] |=> cmd_q.override)
        else $error("override not applied");

    a_trip_request: assert property (@(posedge mclk) disable iff (rst)
        fn_act[drive_cmd_pkg::FN_TRIP] |=> cmd_q.trip_reset)
        else $error("trip reset not requested");

endmodule : drive_run_command_logic

// >>> verif/contact_strip_model.sv
// Terminal strip model: eight dry contacts, each pulled low when open.
// Assumes the bench calls set_pins from its main process.
`timescale 1ns/1ps

module contact_strip_model (
    // Clock
    input  wire logic       mclk,
    // Terminal pins
    output logic      [7:0] din
);
    logic [7:0] level_q;    // Open contacts read low through the pull-downs

    initial level_q = 8'h00;

    // Contacts move just after an edge so the block never sees a race
    task automatic set_pins(input logic [7:0] v);
        @(posedge mclk);
        level_q <= v;
    endtask : set_pins

    // Pins follow the contact states
    assign din = level_q;
endmodule : contact_strip_model

// >>> verif/tb_top.sv
// Bench for the run-command block: single-function table, then logic blocks,
// latching, local mode, bipolar, assignment, edges and reset.
// Assumes the contact model drives the pins and this bench is bus master.
`timescale 1ns/1ps

module tb_top;
    // One single-function case
    typedef struct {
        int         slot;
        logic       refa;
        logic       perm;
        logic [8:0] on;
        logic [8:0] off;
    } row_t;

    logic                      mclk;
    logic                      rst;
    logic [7:0]                address;
    logic                      read;
    logic                      write;
    logic [31:0]               writedata;
    logic [31:0]               readdata;
    logic                      waitrequest;
    logic [7:0]                din;
    logic                      drive_enable;
    logic                      console_run;
    logic                      console_reverse;
    logic                      console_ref_active;
    drive_cmd_pkg::drive_cmd_t cmd;
    logic [31:0]               cmd32;
    logic [31:0]               rd;
    logic [7:0]                tt [4];
    row_t                      rows [12];
    int                        n_mismatch;
    int                        tests_run;
    int                        i;
    int                        m;
    int                        n;

    assign cmd32 = 32'(cmd);

    // Clock at 25 MHz
    initial mclk = 1'b0;
    always #20 mclk = ~mclk;

    drive_run_command_logic drive_run_command_logic_inst (
        .mclk(mclk), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .din(din), .drive_enable(drive_enable), .console_run(console_run),
        .console_reverse(console_reverse), .console_ref_active(console_ref_active),
        .cmd(cmd)
    );

    contact_strip_model contact_strip_model_inst (
        .mclk(mclk),
        .din(din)
    );

    task automatic stop_test;
        if (n_mismatch == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Avalon cycle; request held until the rising edge that sees waitrequest low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        @(posedge mclk);
        address <= a;
        writedata <= wd;
        write <= wr;
        read <= ~wr;
        for (k = 0; k < 20; k++)
        begin
            @(posedge mclk);
            if (waitrequest === 1'b0)
                break;
        end
        if (k == 20)
        begin
            n_mismatch++;
            stop_test();
        end
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus

    function automatic logic [7:0] sel_addr(input int s);
        sel_addr = drive_cmd_pkg::OFS_SEL_BASE + 8'(4 * s);
    endfunction : sel_addr

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wreg

    task automatic rreg(input logic [7:0] a);
        bus(1'b0, a, 32'h0);
    endtask : rreg

    task automatic wsel(input int s, input logic [31:0] d);
        wreg(sel_addr(s), d);
    endtask : wsel

    task automatic pins(input logic [7:0] v);
        contact_strip_model_inst.set_pins(v);
    endtask : pins

    task automatic ctl(input logic en, input logic run, input logic rv, input logic ra);
        @(posedge mclk);
        drive_enable <= en;
        console_run <= run;
        console_reverse <= rv;
        console_ref_active <= ra;
    endtask : ctl

    // Longer than the three-cycle path through a logic block
    task automatic settle;
        repeat (5) @(posedge mclk);
        @(negedge mclk);
    endtask : settle

    task automatic pulses(output int c);
        c = 0;
        repeat (6)
        begin
            @(negedge mclk);
            if (cmd.trip_reset === 1'b1)
                c++;
        end
    endtask : pulses

    // Guard against a hang anywhere
    initial
    begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        stop_test();
    end

    initial
    begin
        rst = 1'b1;
        address = 8'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        drive_enable = 1'b0;
        console_run = 1'b0;
        console_reverse = 1'b0;
        console_ref_active = 1'b0;
        n_mismatch = 0;
        tests_run = 0;
        tt = '{8'h96, 8'h2B, 8'hD1, 8'h6C};
        rows = '{
            '{drive_cmd_pkg::FN_UP,   1'b1, 1'b0, 9'h022, 9'h002},
            '{drive_cmd_pkg::FN_UP,   1'b0, 1'b0, 9'h002, 9'h002},
            '{drive_cmd_pkg::FN_DOWN, 1'b1, 1'b0, 9'h012, 9'h002},
            '{drive_cmd_pkg::FN_DOWN, 1'b0, 1'b0, 9'h002, 9'h002},
            '{drive_cmd_pkg::FN_TRIP, 1'b0, 1'b0, 9'h00A, 9'h002},
            '{drive_cmd_pkg::FN_OVR,  1'b0, 1'b0, 9'h006, 9'h002},
            '{drive_cmd_pkg::FN_JOGF, 1'b0, 1'b0, 9'h142, 9'h002},
            '{drive_cmd_pkg::FN_JOGR, 1'b0, 1'b0, 9'h002, 9'h002},
            '{drive_cmd_pkg::FN_JOGR, 1'b0, 1'b1, 9'h1C2, 9'h002},
            '{drive_cmd_pkg::FN_HFWD, 1'b0, 1'b0, 9'h102, 9'h002},
            '{drive_cmd_pkg::FN_HREV, 1'b0, 1'b0, 9'h002, 9'h002},
            '{drive_cmd_pkg::FN_HREV, 1'b0, 1'b1, 9'h182, 9'h002}};
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        check(cmd32, 32'h0);
        rreg(sel_addr(drive_cmd_pkg::FN_LFWD));
        check(rd, 32'h0C);
        rreg(8'h7C);
        check(rd, 32'h0);
        rreg(8'h61);
        check(rd, 32'h0);
        wreg(drive_cmd_pkg::OFS_STAT, 32'h1FF);
        rreg(drive_cmd_pkg::OFS_STAT);
        check(rd, 32'h200);
        // Remote control with the run permit held, one function at a time
        wsel(drive_cmd_pkg::FN_PERMIT, 32'h0D);
        wsel(drive_cmd_pkg::FN_REMOTE, 32'h0D);
        for (i = 0; i < 12; i++)
        begin
            ctl(1'b1, 1'b0, 1'b0, rows[i].refa);
            wreg(drive_cmd_pkg::OFS_CTRL, {31'h0, rows[i].perm});
            wsel(rows[i].slot, 32'h00);
            pins(8'h01);
            settle();
            check(cmd32, 32'(rows[i].on));
            pins(8'h00);
            settle();
            check(cmd32, 32'(rows[i].off));
            wsel(rows[i].slot, 32'h0C);
        end
        // Every term of every logic block, routed to the trip-reset function
        for (i = 0; i < 4; i++)
        begin
            wreg(drive_cmd_pkg::OFS_TT_BASE + 8'(4 * i), 32'(tt[i]));
            for (m = 0; m < 3; m++)
                wsel(drive_cmd_pkg::FN_LB_IN0 + 3 * i + m, 32'(m));
            wsel(drive_cmd_pkg::FN_TRIP, 32'(drive_cmd_pkg::SRC_LB0) + 32'(i));
            for (m = 0; m < 8; m++)
            begin
                pins({5'h0, m[0], m[1], m[2]});
                settle();
                check(cmd32, tt[i][m] ? 32'h00A : 32'h002);
                rreg(drive_cmd_pkg::OFS_STAT);
                check({31'h0, rd[12 + i]}, {31'h0, tt[i][m]});
            end
        end
        wsel(drive_cmd_pkg::FN_TRIP, 32'h0C);
        // Latched forward on a rising edge, broken by the run permit
        wsel(drive_cmd_pkg::FN_LFWD, 32'h23);
        wsel(drive_cmd_pkg::FN_PERMIT, 32'h04);
        pins(8'h10);
        pins(8'h18);
        pins(8'h10);
        settle();
        check(cmd32, 32'h102);
        rreg(drive_cmd_pkg::OFS_STAT);
        check({29'h0, rd[11:9]}, 32'h2);
        pins(8'h00);
        settle();
        check(cmd32, 32'h002);
        // Latched reverse refused, then allowed, then broken by jog
        wsel(drive_cmd_pkg::FN_LFWD, 32'h0C);
        wsel(drive_cmd_pkg::FN_LREV, 32'h23);
        wreg(drive_cmd_pkg::OFS_CTRL, 32'h0);
        pins(8'h10);
        pins(8'h18);
        pins(8'h10);
        settle();
        check(cmd32, 32'h002);
        wreg(drive_cmd_pkg::OFS_CTRL, 32'h1);
        pins(8'h18);
        pins(8'h10);
        settle();
        check(cmd32, 32'h182);
        wsel(drive_cmd_pkg::FN_JOGF, 32'h06);
        pins(8'h50);
        settle();
        check(cmd32, 32'h142);
        pins(8'h10);
        settle();
        check(cmd32, 32'h002);
        // Local mode keeps the latch although the permit drops
        wsel(drive_cmd_pkg::FN_REMOTE, 32'h07);
        pins(8'h98);
        pins(8'h90);
        settle();
        check(cmd32, 32'h182);
        pins(8'h00);
        settle();
        check(cmd32, 32'h000);
        pins(8'h90);
        settle();
        check(cmd32, 32'h182);
        pins(8'h00);
        ctl(1'b1, 1'b1, 1'b1, 1'b0);
        settle();
        check(cmd32, 32'h180);
        pins(8'h80);
        settle();
        check(cmd32, 32'h002);
        ctl(1'b1, 1'b0, 1'b0, 1'b0);
        // Both hold functions assigned, permit low throughout
        wsel(drive_cmd_pkg::FN_HFWD, 32'h01);
        wsel(drive_cmd_pkg::FN_HREV, 32'h02);
        settle();
        check(cmd32, 32'h003);
        pins(8'h82);
        settle();
        check(cmd32, 32'h103);
        ctl(1'b0, 1'b0, 1'b0, 1'b0);
        settle();
        check(cmd32, 32'h003);
        ctl(1'b1, 1'b0, 1'b0, 1'b0);
        pins(8'h84);
        settle();
        check(cmd32, 32'h183);
        pins(8'h80);
        // Assignment with removal strips other users of pin 1
        wsel(drive_cmd_pkg::FN_TRIP, 32'h01);
        wreg(drive_cmd_pkg::OFS_ASSIGN, 32'h0001_0401);
        rreg(sel_addr(drive_cmd_pkg::FN_TRIP));
        check(rd, 32'h0C);
        rreg(sel_addr(drive_cmd_pkg::FN_HFWD));
        check(rd, 32'h0C);
        rreg(sel_addr(drive_cmd_pkg::FN_HREV));
        check(rd, 32'h01);
        // Edge qualifiers give one pulse, low level inverts
        wsel(drive_cmd_pkg::FN_TRIP, 32'h25);
        pins(8'hA0);
        pulses(n);
        check(32'(n), 32'h1);
        wsel(drive_cmd_pkg::FN_TRIP, 32'h35);
        pins(8'h80);
        pulses(n);
        check(32'(n), 32'h1);
        wsel(drive_cmd_pkg::FN_OVR, 32'h15);
        settle();
        check(cmd32, 32'h006);
        // Reset in mid-run restores defaults
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        check(cmd32, 32'h0);
        @(posedge mclk);
        rst <= 1'b0;
        rreg(sel_addr(drive_cmd_pkg::FN_OVR));
        check(rd, 32'h0C);
        rreg(drive_cmd_pkg::OFS_TT_BASE + 8'h04);
        check(rd, 32'h0);
        rreg(drive_cmd_pkg::OFS_CTRL);
        check(rd, 32'h0);
        stop_test();
    end
endmodule : tb_top
